// ---- rtl/ucd_pkg.sv ----
package ucd_pkg;
  // Register indexes; byte address on the bus is four times the index
  localparam logic [5:0] IDX_LINE_DEBUG  = 6'h15;
  localparam logic [5:0] IDX_SCRATCH     = 6'h16;
  localparam logic [5:0] IDX_SW_CTRL     = 6'h19;
  localparam logic [5:0] IDX_IRQ_EN      = 6'h1d;
  localparam logic [5:0] IDX_IRQ_STATUS  = 6'h20;
  localparam logic [5:0] IDX_MEAS_CONV   = 6'h36;
  localparam logic [5:0] OFS_SET         = 6'h01;
  localparam logic [5:0] OFS_CLR         = 6'h02;

  // Switch control fields
  localparam int CTRL_ID_PULLDOWN = 1;
  localparam int CTRL_TX_ROUTE    = 2;
  localparam int CTRL_RX_ROUTE    = 3;
  localparam int CTRL_LEFT        = 4;
  localparam int CTRL_RIGHT       = 5;
  localparam int CTRL_MIC         = 6;
  localparam logic [7:0] CTRL_MASK = 8'h7e;

  // Interrupt enable fields
  localparam int IEN_OPEN_RISE = 0;
  localparam int IEN_OPEN_FALL = 1;
  localparam int IEN_MEAS      = 5;
  localparam logic [7:0] IEN_MASK = 8'h23;

  // Status fields
  localparam int STS_OPEN      = 0;
  localparam int STS_RESULT_LO = 3;
  localparam int STS_DONE      = 6;

  // Measurement conversion register fields
  localparam int CONV_DONE     = 3;
  localparam int CONV_START    = 4;
  localparam int CONV_IRQ_EN   = 6;
  localparam logic [7:0] CONV_MASK = 8'h70;

  localparam logic [7:0] SCRATCH_MASK = 8'hff;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // Measurement time
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MEAS_TIME_US  = 282;
  localparam int unsigned MEAS_CYCLES   = (MEAS_TIME_US * 1000) / CLK_PERIOD_NS;
endpackage

// ---- rtl/ucd_setclr_reg.sv ----
module ucd_setclr_reg #(
  parameter logic [5:0] BASE  = 6'h00,
  parameter logic [7:0] MASK  = 8'hff,
  parameter logic [7:0] RESET = 8'h00
) (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // Bus commit
  input  wire logic [5:0] i_idx,
  input  wire logic       i_wr_commit,
  input  wire logic [7:0] i_wdata,
  // Hardware clear
  input  wire logic [7:0] i_hw_clr,
  // Value
  output logic      [7:0] o_value
);
  logic [7:0] value_ff;
  logic [7:0] nxt_value;
  wire        hit_wr  = i_wr_commit && (i_idx == BASE);
  wire        hit_set = i_wr_commit && (i_idx == BASE + ucd_pkg::OFS_SET);
  wire        hit_clr = i_wr_commit && (i_idx == BASE + ucd_pkg::OFS_CLR);
  wire  [7:0] wmask   = i_wdata & MASK;

  // Fixed bits never take written ones
  always_comb begin
    nxt_value = value_ff & ~i_hw_clr;
    if (hit_wr) begin
      nxt_value = wmask;
    end else if (hit_set) begin
      nxt_value = value_ff | wmask;
    end else if (hit_clr) begin
      nxt_value = value_ff & ~wmask;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      value_ff <= RESET;
    end else begin
      value_ff <= nxt_value & MASK;
    end
  end

  assign o_value = value_ff;
endmodule

// ---- rtl/ucd_meas_timer.sv ----
module ucd_meas_timer #(
  parameter int unsigned CYCLES = 100
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_run,
  output logic      o_done
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] cnt_ff;
  logic         done_ff;

  // Dropping run aborts and rewinds the count
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_run || done_ff) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= cnt_ff + W'(1);
      done_ff <= (cnt_ff == LAST);
    end
  end

  assign o_done = done_ff;
endmodule

// ---- rtl/ucd_regs.sv ----
//
// Summary of operation
// - Debug register returns live line state in bits 1:0, upper bits zero.
// - Scratch byte supports write, set, clear, resets to zero, affects nothing.
// - Settable registers: base loads, base+1 sets ones, base+2 clears ones.
// - With receive routing clear, data line 1 is held high.
// - Control bit 1 pulls the ID pin to ground.
// - Control bit 2 routes data line 0 transmit onto DM.
// - Control bit 3 routes DP onto data line 1 receive.
// - Control bit 4 closes DM to left audio pin switch.
// - DP connects to right audio pin while bit 5 or 6 set.
// - UART traffic also appears on audio pins with closed switches.
// - Single-ended receivers disabled while any audio switch bit set.
// - Enable bit 0: ID becoming open raises alt_int.
// - Enable bit 1: ID leaving open raises alt_int.
// - Enable bit 5 OR vendor enable: measurement completion with done clear raises alt_int.
// - Unimplemented and reserved bits read as zero.
// - Status bit 0 reads one while ID open with pull-up enabled.
// - Status bits 5:3 report the resistor measurement result code.
// - Status bit 6 sets on completion; measurement takes 282 us.
// - Done clears only on conversion register read, not status read.
//
// Chosen here: the Wishbone interface to the registers.
module ucd_regs #(
  parameter int unsigned MEAS_CYCLES = ucd_pkg::MEAS_CYCLES
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Transceiver state inputs
  input  wire logic [1:0]  i_line_state,
  input  wire logic        i_id_open_raw,
  input  wire logic        i_id_pin_pullup_en,
  input  wire logic [2:0]  i_resistor_code,
  input  wire logic        i_accessory_mode_sel,
  input  wire logic        i_ulpi_data0,
  input  wire logic        i_dp_level,
  // Pin and switch controls
  output logic             o_id_pin_pulldown,
  output logic             o_uart_tx_route_en,
  output logic             o_uart_rx_route_en,
  output logic             o_audio_left_switch,
  output logic             o_audio_right_switch,
  output logic             o_se_rx_disable,
  output logic             o_meas_busy,
  // Line drives
  output logic             o_ulpi_data1,
  output logic             o_ulpi_data1_oe,
  output logic             o_dm_out,
  output logic             o_dm_oe,
  output logic             o_audio_left_pin,
  output logic             o_audio_right_pin,
  // Event to RXCMD builder
  output logic             o_alt_int
);
  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {i_dp_level, i_ulpi_data0, i_resistor_code, i_id_open_raw, i_line_state};
      sync2_ff <= sync1_ff;
    end
  end

  wire [1:0] line_state_s = sync2_ff[1:0];
  wire       id_open_s    = sync2_ff[2];
  wire [2:0] res_code_s   = sync2_ff[5:3];
  wire       data0_s      = sync2_ff[6];
  wire       dp_s         = sync2_ff[7];

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone handshake: answer one cycle after the request, commit at the ack edge
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [7:0]  rd_mux;

  wire       req       = i_wb_cyc && i_wb_stb;
  wire [5:0] idx       = i_wb_adr[7:2];
  wire       commit    = req && ack_ff;
  wire       wr_commit = commit && i_wb_we && i_wb_sel[0];
  wire       rd_commit = commit && !i_wb_we;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req && !ack_ff;
      if (req && !ack_ff) begin
        dat_ff <= {24'h00_0000, rd_mux};
      end
    end
  end

  assign o_wb_ack = ack_ff;
  assign o_wb_dat = dat_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Settable registers
  logic [7:0] scratch;
  logic [7:0] ctrl;
  logic [7:0] irq_en;
  logic [7:0] conv;
  logic       meas_done_pulse;

  wire [7:0] conv_hw_clr = meas_done_pulse ? (8'h01 << ucd_pkg::CONV_START) : 8'h00;

  ucd_setclr_reg #(
    .BASE  (ucd_pkg::IDX_SCRATCH),
    .MASK  (ucd_pkg::SCRATCH_MASK),
    .RESET (ucd_pkg::RESET_BYTE)
  ) u_scratch (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_idx       (idx),
    .i_wr_commit (wr_commit),
    .i_wdata     (i_wb_dat[7:0]),
    .i_hw_clr    (8'h00),
    .o_value     (scratch)
  );

  ucd_setclr_reg #(
    .BASE  (ucd_pkg::IDX_SW_CTRL),
    .MASK  (ucd_pkg::CTRL_MASK),
    .RESET (ucd_pkg::RESET_BYTE)
  ) u_ctrl (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_idx       (idx),
    .i_wr_commit (wr_commit),
    .i_wdata     (i_wb_dat[7:0]),
    .i_hw_clr    (8'h00),
    .o_value     (ctrl)
  );

  ucd_setclr_reg #(
    .BASE  (ucd_pkg::IDX_IRQ_EN),
    .MASK  (ucd_pkg::IEN_MASK),
    .RESET (ucd_pkg::RESET_BYTE)
  ) u_irq_en (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_idx       (idx),
    .i_wr_commit (wr_commit),
    .i_wdata     (i_wb_dat[7:0]),
    .i_hw_clr    (8'h00),
    .o_value     (irq_en)
  );

  ucd_setclr_reg #(
    .BASE  (ucd_pkg::IDX_MEAS_CONV),
    .MASK  (ucd_pkg::CONV_MASK),
    .RESET (ucd_pkg::RESET_BYTE)
  ) u_conv (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_idx       (idx),
    .i_wr_commit (wr_commit),
    .i_wdata     (i_wb_dat[7:0]),
    .i_hw_clr    (conv_hw_clr),
    .o_value     (conv)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Resistor measurement
  wire meas_run = conv[ucd_pkg::CONV_START];

  ucd_meas_timer #(
    .CYCLES (MEAS_CYCLES)
  ) u_meas_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_run     (meas_run),
    .o_done    (meas_done_pulse)
  );

  logic [2:0] result_ff;
  logic       done_ff;

  wire conv_read = rd_commit && (idx >= ucd_pkg::IDX_MEAS_CONV)
                   && (idx <= ucd_pkg::IDX_MEAS_CONV + ucd_pkg::OFS_CLR);

  // Completion wins over a read-clear landing in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      result_ff <= 3'h0;
      done_ff   <= 1'b0;
    end else if (meas_done_pulse) begin
      result_ff <= res_code_s;
      done_ff   <= 1'b1;
    end else if (conv_read) begin
      done_ff   <= 1'b0;
    end
  end

  assign o_meas_busy = meas_run;

  //////////////////////////////////////////////////////////////////////////////
  // Alt interrupt events
  logic id_open_prev_ff;
  logic alt_int_ff;

  // Syncs restart at zero; an ID idling open would fake a rise
  logic [1:0] settle_ff;
  logic [1:0] nxt_settle;
  wire        settled = (settle_ff == 2'h3);

  assign nxt_settle = settled ? settle_ff : settle_ff + 2'h1;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      settle_ff <= 2'h0;
    end else begin
      settle_ff <= nxt_settle;
    end
  end

  wire open_rise = settled && id_open_s && !id_open_prev_ff;
  wire open_fall = settled && !id_open_s && id_open_prev_ff;
  wire meas_ien  = irq_en[ucd_pkg::IEN_MEAS] || conv[ucd_pkg::CONV_IRQ_EN];
  wire alt_event = (open_rise && irq_en[ucd_pkg::IEN_OPEN_RISE])
                   || (open_fall && irq_en[ucd_pkg::IEN_OPEN_FALL])
                   || (meas_done_pulse && !done_ff && meas_ien);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      id_open_prev_ff <= 1'b0;
      alt_int_ff      <= 1'b0;
    end else begin
      id_open_prev_ff <= id_open_s;
      alt_int_ff      <= alt_event;
    end
  end

  assign o_alt_int = alt_int_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [7:0] debug_val  = {6'h00, line_state_s};
  wire       open_flag  = id_open_s && i_id_pin_pullup_en;
  wire [7:0] status_val = {1'b0, done_ff, result_ff, 2'b00, open_flag};
  wire [7:0] conv_val   = {1'b0, conv[6:4], done_ff, result_ff};

  always_comb begin
    case (idx)
      ucd_pkg::IDX_LINE_DEBUG: rd_mux = debug_val;
      ucd_pkg::IDX_SCRATCH,
      ucd_pkg::IDX_SCRATCH + ucd_pkg::OFS_SET,
      ucd_pkg::IDX_SCRATCH + ucd_pkg::OFS_CLR: rd_mux = scratch;
      ucd_pkg::IDX_SW_CTRL,
      ucd_pkg::IDX_SW_CTRL + ucd_pkg::OFS_SET,
      ucd_pkg::IDX_SW_CTRL + ucd_pkg::OFS_CLR: rd_mux = ctrl;
      ucd_pkg::IDX_IRQ_EN,
      ucd_pkg::IDX_IRQ_EN + ucd_pkg::OFS_SET,
      ucd_pkg::IDX_IRQ_EN + ucd_pkg::OFS_CLR: rd_mux = irq_en;
      ucd_pkg::IDX_IRQ_STATUS: rd_mux = status_val;
      ucd_pkg::IDX_MEAS_CONV,
      ucd_pkg::IDX_MEAS_CONV + ucd_pkg::OFS_SET,
      ucd_pkg::IDX_MEAS_CONV + ucd_pkg::OFS_CLR: rd_mux = conv_val;
      default: rd_mux = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Switch controls and line drives
  wire tx_en = ctrl[ucd_pkg::CTRL_TX_ROUTE];
  wire rx_en = ctrl[ucd_pkg::CTRL_RX_ROUTE];
  wire left  = ctrl[ucd_pkg::CTRL_LEFT];
  wire right = ctrl[ucd_pkg::CTRL_RIGHT] || ctrl[ucd_pkg::CTRL_MIC];

  assign o_id_pin_pulldown    = ctrl[ucd_pkg::CTRL_ID_PULLDOWN];
  assign o_uart_tx_route_en   = tx_en;
  assign o_uart_rx_route_en   = rx_en;
  assign o_audio_left_switch  = left;
  assign o_audio_right_switch = right;
  assign o_se_rx_disable      = left || right;

  logic data1_ff;
  logic data1_oe_ff;
  logic dm_ff;
  logic dm_oe_ff;
  logic aud_l_ff;
  logic aud_r_ff;

  // Routing only takes hold once the link has selected accessory mode
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      data1_ff    <= 1'b1;
      data1_oe_ff <= 1'b0;
      dm_ff       <= 1'b0;
      dm_oe_ff    <= 1'b0;
      aud_l_ff    <= 1'b0;
      aud_r_ff    <= 1'b0;
    end else begin
      data1_ff    <= rx_en ? dp_s : 1'b1;
      data1_oe_ff <= i_accessory_mode_sel;
      dm_ff       <= data0_s;
      dm_oe_ff    <= i_accessory_mode_sel && tx_en;
      aud_l_ff    <= i_accessory_mode_sel && tx_en && left && data0_s;
      aud_r_ff    <= i_accessory_mode_sel && rx_en && right && dp_s;
    end
  end

  assign o_ulpi_data1      = data1_ff;
  assign o_ulpi_data1_oe   = data1_oe_ff;
  assign o_dm_out          = dm_ff;
  assign o_dm_oe           = dm_oe_ff;
  assign o_audio_left_pin  = aud_l_ff;
  assign o_audio_right_pin = aud_r_ff;
endmodule

// ---- bench/ucd_regs_properties.sv ----
module ucd_regs_properties #(
  parameter int unsigned MEAS_CYCLES = 20
) (
  // Clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  // Bus
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // Controls and pins
  input wire logic        i_accessory_mode_sel,
  input wire logic        o_id_pin_pulldown,
  input wire logic        o_uart_tx_route_en,
  input wire logic        o_uart_rx_route_en,
  input wire logic        o_audio_left_switch,
  input wire logic        o_audio_right_switch,
  input wire logic        o_se_rx_disable,
  input wire logic        o_meas_busy,
  input wire logic        o_ulpi_data1,
  input wire logic        o_dm_oe,
  input wire logic        o_audio_left_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;
  // Counts only while a conversion is pending
  assign nxt_busy_cnt = o_meas_busy ? busy_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge i_ref_clk) begin
    busy_cnt_ff <= i_rst ? 32'h0000_0000 : nxt_busy_cnt;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_ack_answer; (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
  property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_upper; o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000; endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("upper data set");
  property p_data1_idle; (!o_uart_rx_route_en && $past(!o_uart_rx_route_en)) |-> o_ulpi_data1;
  endproperty
  a_data1_idle: assert property (p_data1_idle) else $error("data1 not high");
  property p_dm_on; (i_accessory_mode_sel && o_uart_tx_route_en) |=> o_dm_oe; endproperty
  a_dm_on: assert property (p_dm_on) else $error("dm not driven");
  property p_dm_off; !i_accessory_mode_sel |=> !o_dm_oe; endproperty
  a_dm_off: assert property (p_dm_off) else $error("dm driven outside mode");
  property p_left_pin;
    o_audio_left_pin |-> $past(o_audio_left_switch && i_accessory_mode_sel && o_uart_tx_route_en);
  endproperty
  a_left_pin: assert property (p_left_pin) else $error("left pin without path");
  property p_se_rx; o_se_rx_disable == (o_audio_left_switch || o_audio_right_switch); endproperty
  a_se_rx: assert property (p_se_rx) else $error("receiver disable wrong");
  property p_pulldown_cause; $changed(o_id_pin_pulldown) |-> $past(o_wb_ack && i_wb_we);
  endproperty
  a_pulldown_cause: assert property (p_pulldown_cause) else $error("pulldown moved");
  property p_meas_len; o_meas_busy |-> busy_cnt_ff <= MEAS_CYCLES + 2; endproperty
  a_meas_len: assert property (p_meas_len) else $error("conversion too long");
endmodule

// ---- bench/ucd_link_model.sv ----
module ucd_link_model (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Bench requests
  input  wire logic i_want_mode,
  input  wire logic i_pullup_req,
  input  wire logic i_tx_bit,
  input  wire logic i_rx_line,
  // Route state seen
  input  wire logic i_tx_route,
  input  wire logic i_rx_route,
  // Toward the device
  output logic      o_mode_ff,
  output logic      o_pullup,
  output logic      o_data0_ff,
  output logic      o_dp_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bench drops the pull-up only while open-ID events are disabled
  assign o_pullup = i_pullup_req;
  always_ff @(posedge i_ref_clk) begin
    o_mode_ff  <= !i_rst && i_want_mode && (o_mode_ff || i_tx_route || i_rx_route);
    o_data0_ff <= i_tx_bit;
    o_dp_ff    <= i_rx_line;
  end
endmodule

// ---- bench/tb_ulpi_carkit_debug_registers.sv ----
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_ulpi_carkit_debug_registers;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MC = 20;
  logic i_ref_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
  logic [7:0] i_wb_adr, rdv, alt_cnt, a0;
  logic [3:0] i_wb_sel, sel_req;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic [1:0] i_line_state;
  logic [2:0] i_resistor_code;
  logic i_id_open_raw, i_id_pin_pullup_en, i_accessory_mode_sel, i_ulpi_data0, i_dp_level;
  logic o_id_pin_pulldown, o_uart_tx_route_en, o_uart_rx_route_en, o_audio_left_switch;
  logic o_audio_right_switch, o_se_rx_disable, o_meas_busy, o_ulpi_data1, o_ulpi_data1_oe;
  logic o_dm_out, o_dm_oe, o_audio_left_pin, o_audio_right_pin, o_alt_int;
  logic want_mode, tx_bit, rx_line, pull_req;
  int err_count, checks_done, n;
  ucd_regs #(.MEAS_CYCLES(MC)) dut (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_line_state, .i_id_open_raw,
    .i_id_pin_pullup_en, .i_resistor_code, .i_accessory_mode_sel, .i_ulpi_data0, .i_dp_level,
    .o_id_pin_pulldown, .o_uart_tx_route_en, .o_uart_rx_route_en, .o_audio_left_switch,
    .o_audio_right_switch, .o_se_rx_disable, .o_meas_busy, .o_ulpi_data1, .o_ulpi_data1_oe,
    .o_dm_out, .o_dm_oe, .o_audio_left_pin, .o_audio_right_pin, .o_alt_int);
  ucd_link_model u_link (.i_ref_clk, .i_rst, .i_want_mode(want_mode), .i_pullup_req(pull_req),
    .i_tx_bit(tx_bit), .i_rx_line(rx_line), .i_tx_route(o_uart_tx_route_en),
    .i_rx_route(o_uart_rx_route_en),
    .o_mode_ff(i_accessory_mode_sel), .o_pullup(i_id_pin_pullup_en),
    .o_data0_ff(i_ulpi_data0), .o_dp_ff(i_dp_level));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) if (o_alt_int === 1'b1) alt_cnt++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wb(input logic [5:0] idx, input logic w, input logic [7:0] d);
    int k;
    @(posedge i_ref_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= w;
    i_wb_adr <= {idx, 2'b00};
    i_wb_dat <= {24'h00_0000, d};
    i_wb_sel <= sel_req;
    for (k = 0; k < 16; k++) begin
      @(posedge i_ref_clk);
      if (o_wb_ack === 1'b1) break;
    end
    rdv = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
    if (k == 16) begin err_count++; complete_run(); end
  endtask
  task automatic tick(input int c); repeat (c) @(posedge i_ref_clk); endtask
  task automatic meas(input logic [7:0] v);
    wb(6'h36, 1'b1, v);
    for (n = 0; n < 200; n++) begin
      @(posedge i_ref_clk);
      if (o_meas_busy !== 1'b1) break;
    end
    `CHK("meas_len", 1'b1, (n >= MC - 1 && n <= MC + 2))
    if (n == 200) complete_run();
    tick(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [5:0] idx [5] = '{6'h15, 6'h16, 6'h19, 6'h1d, 6'h20};
    foreach (idx[i]) begin wb(idx[i], 1'b0, 8'h00); `CHK("reset", 8'h00, rdv) end
    i_line_state <= 2'b10;
    tick(4);
    wb(6'h15, 1'b1, 8'hff);
    wb(6'h15, 1'b0, 8'h00); `CHK("debug", 8'h02, rdv)
    wb(6'h16, 1'b1, 8'ha5);
    wb(6'h17, 1'b1, 8'h5a);
    wb(6'h18, 1'b0, 8'h00); `CHK("scr_set", 8'hff, rdv)
    wb(6'h18, 1'b1, 8'h0f);
    wb(6'h17, 1'b0, 8'h00); `CHK("scr_clr", 8'hf0, rdv)
    sel_req = 4'he;
    wb(6'h16, 1'b1, 8'h33);
    sel_req = 4'h1;
    wb(6'h16, 1'b0, 8'h00); `CHK("sel_low", 8'hf0, rdv)
    wb(6'h3c, 1'b1, 8'hff);
    wb(6'h3c, 1'b0, 8'h00); `CHK("unmapped", 8'h00, rdv)
  endtask
  task automatic t_ctrl;
    wb(6'h19, 1'b1, 8'hff);
    wb(6'h1b, 1'b0, 8'h00); `CHK("ctrl", 8'h7e, rdv)
    `CHK("pulldown", 1'b1, o_id_pin_pulldown)
    `CHK("se_off", 1'b1, o_se_rx_disable)
    wb(6'h1b, 1'b1, 8'h20);
    tick(1); `CHK("right_mic", 1'b1, o_audio_right_switch)
    wb(6'h1b, 1'b1, 8'h40);
    tick(1); `CHK("right_off", 1'b0, o_audio_right_switch)
    `CHK("left", 1'b1, o_audio_left_switch)
    wb(6'h1b, 1'b1, 8'h7e);
    tick(1); `CHK("released", 1'b0, o_id_pin_pulldown)
    `CHK("se_on", 1'b0, o_se_rx_disable)
  endtask
  task automatic t_uart;
    wb(6'h19, 1'b1, 8'h14);
    want_mode <= 1'b1;
    tx_bit    <= 1'b1;
    tick(6); `CHK("dm_oe", 1'b1, o_dm_oe)
    `CHK("dm", 1'b1, o_dm_out)
    `CHK("left_pin", 1'b1, o_audio_left_pin)
    `CHK("d1_idle", 1'b1, o_ulpi_data1)
    `CHK("d1_oe", 1'b1, o_ulpi_data1_oe)
    tx_bit <= 1'b0;
    tick(6); `CHK("left_pin0", 1'b0, o_audio_left_pin)
    wb(6'h1a, 1'b1, 8'h28);
    tick(6); `CHK("d1_dp0", 1'b0, o_ulpi_data1)
    rx_line <= 1'b1;
    tick(6); `CHK("right_pin", 1'b1, o_audio_right_pin)
    `CHK("d1_dp1", 1'b1, o_ulpi_data1)
    want_mode <= 1'b0;
    wb(6'h19, 1'b1, 8'h00);
    wb(6'h19, 1'b1, 8'h70);
    tick(1); `CHK("se_audio", 1'b1, o_se_rx_disable)
    `CHK("dm_audio", 1'b0, o_dm_oe)
    `CHK("d1_oe_off", 1'b0, o_ulpi_data1_oe)
    wb(6'h19, 1'b1, 8'h00);
  endtask
  task automatic t_id;
    wb(6'h1d, 1'b1, 8'hff);
    wb(6'h1e, 1'b0, 8'h00); `CHK("ien", 8'h23, rdv)
    for (int s = 0; s < 4; s++) begin
      a0 = alt_cnt;
      i_id_open_raw <= !s[0];
      tick(8); `CHK("alt_id", {7'h00, s < 2}, alt_cnt - a0)
      if (s == 0) begin wb(6'h20, 1'b0, 8'h00); `CHK("open", 8'h01, rdv) end
      if (s == 1) wb(6'h1f, 1'b1, 8'h01);
      if (s == 2) begin
        wb(6'h1f, 1'b1, 8'h02);
        pull_req <= 1'b0;
        wb(6'h20, 1'b0, 8'h00); `CHK("open_nopull", 8'h00, rdv)
        pull_req <= 1'b1;
      end
    end
  endtask
  task automatic t_meas;
    i_resistor_code <= 3'b011;
    a0 = alt_cnt;
    meas(8'h10); `CHK("alt_meas", a0 + 8'h01, alt_cnt)
    wb(6'h20, 1'b0, 8'h00); `CHK("sts_done", 8'h58, rdv)
    wb(6'h20, 1'b0, 8'h00); `CHK("sts_keep", 8'h58, rdv)
    wb(6'h36, 1'b0, 8'h00); `CHK("conv", 8'h0b, rdv)
    wb(6'h20, 1'b0, 8'h00); `CHK("sts_clr", 8'h18, rdv)
    wb(6'h1f, 1'b1, 8'h20);
    a0 = alt_cnt;
    meas(8'h50); `CHK("alt_vend", a0 + 8'h01, alt_cnt)
  endtask
  initial begin
    {i_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_id_open_raw, want_mode, tx_bit, rx_line} = 8'hff;
    {i_wb_cyc, i_wb_stb, i_wb_we, i_id_open_raw, want_mode, tx_bit, rx_line} = 7'h00;
    {i_wb_adr, i_wb_dat, i_line_state, i_resistor_code, alt_cnt} = '0;
    i_wb_sel = 4'h1;
    sel_req = 4'h1;
    pull_req = 1'b1;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_regs(); $display("t_regs done");
    t_ctrl(); $display("t_ctrl done");
    t_uart(); $display("t_uart done");
    t_id(); $display("t_id done");
    t_meas(); $display("t_meas done");
    complete_run();
  end
endmodule
bind ucd_regs ucd_regs_properties #(.MEAS_CYCLES(MEAS_CYCLES)) u_props (.i_ref_clk, .i_rst,
  .i_wb_cyc, .i_wb_stb, .i_wb_we, .o_wb_dat, .o_wb_ack, .i_accessory_mode_sel,
  .o_id_pin_pulldown, .o_uart_tx_route_en, .o_uart_rx_route_en, .o_audio_left_switch,
  .o_audio_right_switch, .o_se_rx_disable, .o_meas_busy, .o_ulpi_data1, .o_dm_oe,
  .o_audio_left_pin);
